// file: pkg/hsccs_pkg.sv
// Constants and encodings of the counter command and status interface.
package hsccs_pkg;
   // Register byte offsets.
   localparam logic [7:0]  HSCCS_OFF_CMD   = 8'h00;
   localparam logic [7:0]  HSCCS_OFF_STAT  = 8'h04;
   localparam logic [7:0]  HSCCS_OFF_CODE  = 8'h08;
   localparam logic [7:0]  HSCCS_OFF_CFG   = 8'h0C;
   localparam logic [7:0]  HSCCS_OFF_DCW0  = 8'h10;
   localparam logic [7:0]  HSCCS_OFF_DCW1  = 8'h14;
   localparam logic [7:0]  HSCCS_OFF_DCW2  = 8'h18;
   localparam logic [7:0]  HSCCS_OFF_HOME  = 8'h1C;
   // Discrete command word fields.
   localparam int          HSCCS_CMD_SACK  = 0;
   localparam int          HSCCS_CMD_PACK  = 4;
   localparam int          HSCCS_CMD_ARM   = 8;
   localparam int          HSCCS_CMD_OEN   = 9;
   localparam int          HSCCS_CMD_CLR   = 15;
   // Status word fields.
   localparam int          HSCCS_ST_STB    = 0;
   localparam int          HSCCS_ST_PRE    = 4;
   localparam int          HSCCS_ST_FOUND  = 8;
   localparam int          HSCCS_ST_HOMEIN = 9;
   localparam int          HSCCS_ST_OUT    = 10;
   localparam int          HSCCS_ST_READY  = 14;
   localparam int          HSCCS_ST_ERR    = 15;
   // Configuration word fields.
   localparam int          HSCCS_CFG_TYPE  = 0;
   localparam int          HSCCS_CFG_REQ   = 8;
   // Counter types.
   localparam logic [1:0]  HSCCS_TYPE_A    = 2'h0;
   localparam logic [1:0]  HSCCS_TYPE_B    = 2'h1;
   localparam logic [1:0]  HSCCS_TYPE_C    = 2'h2;
   localparam logic [1:0]  HSCCS_TYPE_BAD  = 2'h3;
   localparam logic [7:0]  HSCCS_NCNT_A    = 8'h04;
   localparam logic [7:0]  HSCCS_NCNT_B    = 8'h02;
   localparam logic [7:0]  HSCCS_NCNT_C    = 8'h01;
   // Status codes, one table for every counter type.
   localparam logic [7:0]  HSCCS_ERR_NONE  = 8'h00;
   localparam logic [7:0]  HSCCS_ERR_CMD   = 8'h03;
   localparam logic [7:0]  HSCCS_ERR_PARAM = 8'h04;
   localparam logic [7:0]  HSCCS_ERR_SUB   = 8'h05;
   localparam logic [7:0]  HSCCS_ERR_CNT   = 8'h06;
   localparam logic [7:0]  HSCCS_ERR_HOME  = 8'h0A;
   localparam logic [7:0]  HSCCS_ERR_LIM1  = 8'h0B;
   // Data command codes.
   localparam logic [7:0]  HSCCS_DC_ACC    = 8'h01;
   localparam logic [7:0]  HSCCS_DC_HI     = 8'h02;
   localparam logic [7:0]  HSCCS_DC_LO     = 8'h03;
   localparam logic [7:0]  HSCCS_DC_INC    = 8'h04;
   localparam logic [7:0]  HSCCS_DC_DIR    = 8'h05;
   localparam logic [7:0]  HSCCS_DC_TB     = 8'h06;
   localparam logic [7:0]  HSCCS_DC_ON     = 8'h0B;
   localparam logic [7:0]  HSCCS_DC_OFF    = 8'h15;
   localparam logic [7:0]  HSCCS_DC_PRE    = 8'h1F;
   localparam logic [7:0]  HSCCS_DC_OSC    = 8'h32;
   // Request number accepted by the module; the value is arbitrary.
   localparam logic [7:0]  HSCCS_REQ_NUM   = 8'h01;
   // Reset values.
   localparam logic [15:0] HSCCS_RST_CMD   = 16'h0000;
   localparam logic [31:0] HSCCS_RST_HI    = 32'h0000FFFF;
   localparam logic [31:0] HSCCS_RST_LO    = 32'h00000000;
   localparam logic [31:0] HSCCS_RST_HOME  = 32'h00000000;
   localparam logic [1:0]  HSCCS_RST_TYPE  = HSCCS_TYPE_A;
   // AHB encodings.
   localparam logic [2:0]  HSCCS_HSIZE_W   = 3'h2;
   localparam logic        HSCCS_OKAY      = 1'b0;
endpackage : hsccs_pkg

// file: logic/hsccs_ahb_slv.sv
// AHB-Lite slave front end of the counter command and status interface.
`timescale 1ns/100ps
module hsccs_ahb_slv import hsccs_pkg::*; (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             reg_wr,
   output logic [7:0]       reg_addr,
   output logic [31:0]      reg_wdata,
   input  wire logic [31:0] reg_rdata
);
   typedef enum logic [1:0] {SL_IDLE, SL_WR, SL_RD, SL_RDOUT} hsccs_ph_t;
   typedef struct packed {
      hsccs_ph_t   ph;
      logic [7:0]  addr;
      logic [31:0] rdata;
   } hsccs_slv_t;

   hsccs_slv_t st_r;
   hsccs_slv_t st_nxt;
   logic       take;

   // Reads take one wait state so that read data always comes from a flip-flop.
   always_comb begin
      st_nxt = st_r;
      take   = hsel && htrans[1] && hready && (hsize == HSCCS_HSIZE_W);
      case (st_r.ph)
         SL_RD: begin
            st_nxt.rdata = reg_rdata;
            st_nxt.ph    = SL_RDOUT;
         end
         default: begin
            st_nxt.ph = SL_IDLE;
            if (take) begin
               st_nxt.addr = {haddr[7:2], 2'b00};
               st_nxt.ph   = hwrite ? SL_WR : SL_RD;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= '{ph: SL_IDLE, addr: 8'h00, rdata: 32'h00000000};
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = (st_r.ph != SL_RD);
   assign hresp     = HSCCS_OKAY;
   assign hrdata    = st_r.rdata;
   assign reg_wr    = ce && (st_r.ph == SL_WR);
   assign reg_addr  = st_r.addr;
   assign reg_wdata = hwdata;

   sequence s_rd_take;
      ce && hsel && htrans[1] && hready && !hwrite && (hsize == HSCCS_HSIZE_W);
   endsequence
   AST_RD_ONE_WAIT: assert property (@(posedge clk) disable iff (reset)
      s_rd_take ##1 ce |-> !hreadyout ##1 hreadyout)
      else $error("read did not complete after one wait state");
endmodule : hsccs_ahb_slv

// file: logic/hsccs_top.sv
// Command word, status latches, homing, error code and data command parsing.
`timescale 1ns/100ps
module hsccs_top import hsccs_pkg::*; (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [3:0]  strobe_evt,
   input  wire logic [3:0]  preload_evt,
   input  wire logic [3:0]  out_req,
   input  wire logic        home_switch,
   input  wire logic        marker_in,
   input  wire logic        mem_fault,
   output logic [3:0]       out_on,
   output logic             home_load,
   output logic [31:0]      home_count,
   output logic             home_found,
   output logic             dcmd_valid,
   output logic [7:0]       dcmd_counter,
   output logic [7:0]       dcmd_code,
   output logic [31:0]      dcmd_data,
   output logic [15:0]      status_word,
   output logic [15:0]      analog_input_words,
   output logic             error_flag,
   output logic             module_ready,
   output logic             wdog_kick
);
   typedef struct packed {
      logic [15:0]      cmd;
      logic [3:0]       stb;
      logic [3:0]       pre;
      logic [3:0]       out_on;
      logic             found;
      logic             home_load;
      logic [31:0]      home_cnt;
      logic [1:0]       ctype;
      logic [7:0]       reqnum;
      logic [15:0]      dcw0;
      logic [15:0]      dcw1;
      logic [1:0]       wcnt;
      logic [3:0][31:0] hi;
      logic [3:0][31:0] lo;
      logic             err;
      logic [7:0]       code;
      logic             fault;
      logic             kick;
      logic             dvalid;
      logic [7:0]       dcnt;
      logic [7:0]       dcode;
      logic [31:0]      ddata;
   } hsccs_core_t;

   hsccs_core_t st_r;
   hsccs_core_t st_nxt;

   logic        bus_wr;
   logic [7:0]  bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   logic        cmd_wr;
   logic        err_clr;
   logic [3:0]  sack_clr;
   logic [3:0]  pack_clr;
   logic        arm_now;
   logic        arm_prev;
   logic        evt;
   logic [7:0]  evt_code;
   logic [7:0]  cnum;
   logic [7:0]  ccode;
   logic [1:0]  idx;
   logic [31:0] ddata;
   logic        cnt_ok;
   logic        code_ok;
   logic [7:0]  nmax;

   hsccs_ahb_slv u_slv (
      .clk       (clk),
      .reset     (reset),
      .ce        (ce),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .reg_wr    (bus_wr),
      .reg_addr  (bus_addr),
      .reg_wdata (bus_wdata),
      .reg_rdata (bus_rdata)
   );

   always_comb begin
      st_nxt           = st_r;
      st_nxt.home_load = 1'b0;
      st_nxt.dvalid    = 1'b0;
      evt              = 1'b0;
      evt_code         = HSCCS_ERR_NONE;
      cmd_wr           = bus_wr && (bus_addr == HSCCS_OFF_CMD);
      err_clr          = cmd_wr && bus_wdata[HSCCS_CMD_CLR];
      sack_clr         = cmd_wr ? bus_wdata[HSCCS_CMD_SACK +: 4] : 4'h0;
      pack_clr         = cmd_wr ? bus_wdata[HSCCS_CMD_PACK +: 4] : 4'h0;
      if (cmd_wr) begin
         st_nxt.cmd = bus_wdata[15:0];
      end
      // A new event in the acknowledge cycle wins over the clear.
      st_nxt.stb    = (st_r.stb & ~sack_clr) | strobe_evt;
      st_nxt.pre    = (st_r.pre & ~pack_clr) | preload_evt;
      // Gated with the next command word so that the gate and the output change together.
      st_nxt.out_on = out_req & st_nxt.cmd[HSCCS_CMD_OEN +: 4];

      // Homing only exists for the single-counter type.
      arm_now  = st_nxt.cmd[HSCCS_CMD_ARM] && (st_r.ctype == HSCCS_TYPE_C);
      arm_prev = st_r.cmd[HSCCS_CMD_ARM] && (st_r.ctype == HSCCS_TYPE_C);
      if (arm_now && !arm_prev) begin
         st_nxt.found = 1'b0;
      end
      if (arm_now && home_switch && marker_in && !st_r.found) begin
         st_nxt.home_load = 1'b1;
         st_nxt.found     = 1'b1;
      end
      if (arm_prev && !arm_now && !st_r.found) begin
         evt      = 1'b1;
         evt_code = HSCCS_ERR_HOME;
      end

      if (bus_wr && (bus_addr == HSCCS_OFF_HOME)) begin
         st_nxt.home_cnt = bus_wdata;
      end
      if (bus_wr && (bus_addr == HSCCS_OFF_CFG)) begin
         st_nxt.reqnum = bus_wdata[HSCCS_CFG_REQ +: 8];
         if (bus_wdata[HSCCS_CFG_TYPE +: 2] == HSCCS_TYPE_BAD) begin
            evt      = 1'b1;
            evt_code = HSCCS_ERR_PARAM;
         end else begin
            st_nxt.ctype = bus_wdata[HSCCS_CFG_TYPE +: 2];
         end
      end

      // Three 16-bit words in order make one six-byte command; a broken
      // sequence is dropped so a stale half command is never executed.
      cnum  = st_r.dcw0[15:8];
      ccode = st_r.dcw0[7:0];
      idx   = cnum[1:0] - 2'h1;
      ddata = {bus_wdata[15:0], st_r.dcw1};
      case (st_r.ctype)
         HSCCS_TYPE_B: nmax = HSCCS_NCNT_B;
         HSCCS_TYPE_C: nmax = HSCCS_NCNT_C;
         default:      nmax = HSCCS_NCNT_A;
      endcase
      case (ccode)
         HSCCS_DC_ACC, HSCCS_DC_HI, HSCCS_DC_LO, HSCCS_DC_INC, HSCCS_DC_DIR, HSCCS_DC_TB,
         HSCCS_DC_ON, HSCCS_DC_OFF, HSCCS_DC_PRE: code_ok = (cnum != 8'h00);
         HSCCS_DC_OSC: code_ok = (cnum == 8'h00);
         default:      code_ok = 1'b0;
      endcase
      cnt_ok = ((cnum != 8'h00) && (cnum <= nmax)) ||
               ((cnum == 8'h00) && (ccode == HSCCS_DC_OSC));
      if (bus_wr && (bus_addr == HSCCS_OFF_DCW0)) begin
         st_nxt.dcw0 = bus_wdata[15:0];
         st_nxt.wcnt = 2'h1;
      end else if (bus_wr && (bus_addr == HSCCS_OFF_DCW1)) begin
         st_nxt.dcw1 = bus_wdata[15:0];
         st_nxt.wcnt = (st_r.wcnt == 2'h1) ? 2'h2 : 2'h0;
      end else if (bus_wr && (bus_addr == HSCCS_OFF_DCW2)) begin
         st_nxt.wcnt = 2'h0;
         if (st_r.wcnt == 2'h2) begin
            if (st_r.reqnum != HSCCS_REQ_NUM) begin
               evt      = 1'b1;
               evt_code = HSCCS_ERR_CMD;
            end else if (!cnt_ok) begin
               evt      = 1'b1;
               evt_code = HSCCS_ERR_CNT;
            end else if (!code_ok) begin
               evt      = 1'b1;
               evt_code = HSCCS_ERR_SUB;
            end else if ((ccode == HSCCS_DC_HI) && ($signed(ddata) < $signed(st_r.lo[idx])) ||
                         (ccode == HSCCS_DC_LO) && ($signed(st_r.hi[idx]) < $signed(ddata))) begin
               evt      = 1'b1;
               evt_code = HSCCS_ERR_LIM1 + {6'h00, idx};
            end else begin
               if (ccode == HSCCS_DC_HI) begin
                  st_nxt.hi[idx] = ddata;
               end
               if (ccode == HSCCS_DC_LO) begin
                  st_nxt.lo[idx] = ddata;
               end
               st_nxt.dvalid = 1'b1;
               st_nxt.dcnt   = cnum;
               st_nxt.dcode  = ccode;
               st_nxt.ddata  = ddata;
            end
         end
      end

      // The first error is held; a later one is only taken with a clear.
      if (evt && (!st_r.err || err_clr)) begin
         st_nxt.err  = 1'b1;
         st_nxt.code = evt_code;
      end else if (err_clr) begin
         st_nxt.err  = 1'b0;
         st_nxt.code = HSCCS_ERR_NONE;
      end

      // A memory fault raises no code; the kick simply stops so the watchdog runs out.
      st_nxt.fault = st_r.fault | mem_fault;
      st_nxt.kick  = st_nxt.fault ? st_r.kick : ~st_r.kick;
   end

   always_comb begin
      case (bus_addr)
         HSCCS_OFF_CMD:  bus_rdata = {16'h0000, st_r.cmd};
         HSCCS_OFF_STAT: bus_rdata = {16'h0000, status_word};
         HSCCS_OFF_CODE: bus_rdata = {24'h000000, st_r.code};
         HSCCS_OFF_CFG:  bus_rdata = {16'h0000, st_r.reqnum, 6'h00, st_r.ctype};
         HSCCS_OFF_DCW0: bus_rdata = {16'h0000, st_r.dcw0};
         HSCCS_OFF_DCW1: bus_rdata = {16'h0000, st_r.dcw1};
         HSCCS_OFF_HOME: bus_rdata = st_r.home_cnt;
         default:        bus_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r          <= '0;
         st_r.cmd      <= HSCCS_RST_CMD;
         st_r.ctype    <= HSCCS_RST_TYPE;
         st_r.reqnum   <= HSCCS_REQ_NUM;
         st_r.home_cnt <= HSCCS_RST_HOME;
         st_r.hi       <= {4{HSCCS_RST_HI}};
         st_r.lo       <= {4{HSCCS_RST_LO}};
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign out_on             = st_r.out_on;
   assign home_load          = st_r.home_load;
   assign home_count         = st_r.home_cnt;
   assign home_found         = st_r.found;
   assign dcmd_valid         = st_r.dvalid;
   assign dcmd_counter       = st_r.dcnt;
   assign dcmd_code          = st_r.dcode;
   assign dcmd_data          = st_r.ddata;
   assign analog_input_words = {8'h00, st_r.code};
   assign error_flag         = st_r.err;
   assign module_ready       = !st_r.fault;
   assign wdog_kick          = st_r.kick;
   always_comb begin
      status_word                         = 16'h0000;
      status_word[HSCCS_ST_STB +: 4]      = st_r.stb;
      status_word[HSCCS_ST_PRE +: 4]      = st_r.pre;
      status_word[HSCCS_ST_FOUND]         = st_r.found;
      status_word[HSCCS_ST_HOMEIN]        = home_switch;
      status_word[HSCCS_ST_OUT +: 4]      = st_r.out_on;
      status_word[HSCCS_ST_READY]         = !st_r.fault;
      status_word[HSCCS_ST_ERR]           = st_r.err;
   end

   sequence s_home_hit;
      ce && arm_now && home_switch && marker_in && !st_r.found;
   endsequence
   sequence s_home_done;
      home_load && home_found ##1 !home_load;
   endsequence

   AST_STB_ACK: assert property (@(posedge clk) disable iff (reset)
      ce |=> ((st_r.stb & $past(sack_clr & ~strobe_evt)) == 4'h0))
      else $error("strobe status not cleared by acknowledge");
   AST_PRE_ACK: assert property (@(posedge clk) disable iff (reset)
      ce |=> ((st_r.pre & $past(pack_clr & ~preload_evt)) == 4'h0))
      else $error("preload status not cleared by acknowledge");
   AST_EVT_LATCH: assert property (@(posedge clk) disable iff (reset)
      ce && (strobe_evt != 4'h0) |=> ((st_r.stb & $past(strobe_evt)) == $past(strobe_evt)))
      else $error("strobe event not latched");
   AST_OUT_GATE: assert property (@(posedge clk) disable iff (reset)
      (out_on & ~st_r.cmd[HSCCS_CMD_OEN +: 4]) == 4'h0)
      else $error("output on while its gate is low");
   AST_HOME_LOAD: assert property (@(posedge clk) disable iff (reset)
      s_home_hit ##1 ce |-> s_home_done)
      else $error("home count not loaded on marker");
   AST_HOME_ABORT: assert property (@(posedge clk) disable iff (reset)
      ce && arm_prev && !arm_now && !st_r.found && !st_r.err |=> st_r.code == HSCCS_ERR_HOME)
      else $error("home abort did not report code 10");
   AST_ERR_HOLD: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.err && !err_clr |=> st_r.err && $stable(st_r.code))
      else $error("error code changed without clear");
   AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.err && err_clr && !evt |=> !error_flag && (analog_input_words == 16'h0000))
      else $error("error clear did not zero the code");
   AST_ERR_BIT: assert property (@(posedge clk) disable iff (reset)
      error_flag == (st_r.code != HSCCS_ERR_NONE))
      else $error("error bit and status code disagree");
   AST_FAULT_WDOG: assert property (@(posedge clk) disable iff (reset)
      st_r.fault |=> $stable(wdog_kick) && $stable(st_r.code))
      else $error("watchdog kicked or code changed after memory fault");

   for (genvar g = 0; g < 4; g++) begin : g_lim
      AST_LIMIT_ORDER: assert property (@(posedge clk) disable iff (reset)
         $signed(st_r.hi[g]) >= $signed(st_r.lo[g]))
         else $error("counter high limit below low limit");
   end
endmodule : hsccs_top

// file: bench/hsccs_cpu_model.sv
// Controller CPU model: AHB-Lite master that sends scans and data commands.
`timescale 1ns/100ps
module hsccs_cpu_model import hsccs_pkg::*; (
   input  wire logic        clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   output logic             stuck
);
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata, stuck} = '0;
   end

   // Ready is sampled at the rising edge, so a phase ends exactly where the slave saw it end.
   task automatic wait_rdy(output logic [31:0] q);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1) stuck <= 1'b1;
      q = hrdata;
   endtask : wait_rdy

   task automatic xfer(input logic w, input logic [2:0] sz, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= sz;
      wait_rdy(q);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(q);
      // Stale write data is inverted so it never looks valid by accident.
      hwdata <= ~d;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, HSCCS_HSIZE_W, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, HSCCS_HSIZE_W, a, 32'h00000000, q);
   endtask : rd

   // One scan with the word, then acks and clear drop on the next scan.
   task automatic scan(input logic [15:0] c);
      wr(HSCCS_OFF_CMD, {16'h0000, c});
      wr(HSCCS_OFF_CMD, {16'h0000, c & 16'h7F00});
   endtask : scan

   task automatic send_cmd(input logic [7:0] cnt, input logic [7:0] code,
                           input logic [31:0] d);
      wr(HSCCS_OFF_DCW0, {16'h0000, cnt, code});
      wr(HSCCS_OFF_DCW1, {16'h0000, d[15:0]});
      wr(HSCCS_OFF_DCW2, {16'h0000, d[31:16]});
   endtask : send_cmd
endmodule : hsccs_cpu_model

// file: bench/counter_command_status_interface_bench.sv
// Self-checking bench of the counter command and status interface.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module counter_command_status_interface_bench import hsccs_pkg::*;;
   logic clk, reset, ce, hsel, hwrite, hready, hresp, stuck, home_switch, marker_in;
   logic mem_fault, home_load, home_found, dcmd_valid, error_flag, module_ready;
   logic wdog_kick, w;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] strobe_evt, preload_evt, out_req, out_on;
   logic [7:0] dcmd_counter, dcmd_code;
   logic [15:0] status_word, analog_input_words;
   logic [31:0] haddr, hwdata, hrdata, home_count, dcmd_data, q;
   logic [1:0] types [3] = '{HSCCS_TYPE_A, HSCCS_TYPE_B, HSCCS_TYPE_C};
   logic [7:0] ncnt [3] = '{HSCCS_NCNT_A, HSCCS_NCNT_B, HSCCS_NCNT_C};
   int fails = 0, samples_checked = 0, nvalid = 0, nload = 0;

   hsccs_top u_dut (.clk(clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .strobe_evt(strobe_evt),
      .preload_evt(preload_evt), .out_req(out_req), .home_switch(home_switch),
      .marker_in(marker_in), .mem_fault(mem_fault), .out_on(out_on),
      .home_load(home_load), .home_count(home_count), .home_found(home_found),
      .dcmd_valid(dcmd_valid), .dcmd_counter(dcmd_counter), .dcmd_code(dcmd_code),
      .dcmd_data(dcmd_data), .status_word(status_word),
      .analog_input_words(analog_input_words), .error_flag(error_flag),
      .module_ready(module_ready), .wdog_kick(wdog_kick));
   hsccs_cpu_model u_cpu (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .stuck(stuck));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (dcmd_valid === 1'b1) nvalid++;
      if (home_load === 1'b1) nload++;
   end
   always @(posedge stuck) begin
      fails++;
      complete_run();
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run

   // The extra nanosecond lets the edge's register updates land before a look.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic expect_err(input logic [7:0] e);
      u_cpu.rd(HSCCS_OFF_CODE, q);
      `CHK(q[7:0], e)
      `CHK(analog_input_words, {8'h00, e})
      `CHK(error_flag, e != 8'h00)
      u_cpu.scan(16'h8000);
      tick(1);
      `CHK(analog_input_words, 16'h0000)
      `CHK(error_flag, 1'b0)
   endtask : expect_err

   initial begin
      {strobe_evt, preload_evt, out_req, home_switch, marker_in, mem_fault} = '0;
      ce = 1'b1;
      reset = 1'b1;
      tick(8);
      reset <= 1'b0;
      tick(1);
      u_cpu.rd(HSCCS_OFF_STAT, q);
      `CHK(q[15:0], 16'h4000)
      `CHK(hresp, HSCCS_OKAY)
      strobe_evt <= 4'h4;
      preload_evt <= 4'h2;
      tick(1);
      {strobe_evt, preload_evt} <= '0;
      u_cpu.rd(HSCCS_OFF_STAT, q);
      `CHK(q[7:0], 8'h24)
      u_cpu.scan(16'h0004);
      u_cpu.rd(HSCCS_OFF_STAT, q);
      `CHK(q[7:0], 8'h20)
      u_cpu.scan(16'h0020);
      u_cpu.rd(HSCCS_OFF_STAT, q);
      `CHK(q[7:0], 8'h00)
      out_req <= 4'hF;
      u_cpu.scan(16'h0A00);
      tick(2);
      `CHK(out_on, 4'h5)
      `CHK(status_word[13:10], 4'h5)
      out_req <= 4'hA;
      tick(2);
      `CHK(out_on, 4'h0)
      u_cpu.wr(HSCCS_OFF_CFG, 32'h00000103);
      u_cpu.send_cmd(8'h09, HSCCS_DC_ACC, 32'h0);
      expect_err(HSCCS_ERR_PARAM);
      for (int t = 0; t < 3; t++) begin
         u_cpu.wr(HSCCS_OFF_CFG, {16'h0000, 8'h01, 6'h00, types[t]});
         u_cpu.send_cmd(ncnt[t] + 8'h01, HSCCS_DC_ACC, 32'h0);
         expect_err(HSCCS_ERR_CNT);
         u_cpu.send_cmd(8'h01, 8'h07, 32'h0);
         expect_err(HSCCS_ERR_SUB);
      end
      u_cpu.wr(HSCCS_OFF_CFG, 32'h00000200);
      u_cpu.send_cmd(8'h01, HSCCS_DC_ACC, 32'h0);
      expect_err(HSCCS_ERR_CMD);
      u_cpu.wr(HSCCS_OFF_CFG, 32'h00000100);
      for (int k = 1; k <= 4; k++) begin
         u_cpu.send_cmd(8'(k), HSCCS_DC_HI, 32'hFFFFFFFF);
         expect_err(8'(HSCCS_ERR_LIM1 + k - 1));
      end
      u_cpu.send_cmd(8'h03, HSCCS_DC_ACC, 32'h00001234);
      expect_err(HSCCS_ERR_NONE);
      `CHK({dcmd_counter, dcmd_code, dcmd_data}, 48'h030100001234)
      u_cpu.send_cmd(8'h02, HSCCS_DC_LO, 32'hFFFFFF00);
      u_cpu.send_cmd(8'h01, HSCCS_DC_HI, 32'h00000000);
      expect_err(HSCCS_ERR_NONE);
      `CHK(nvalid, 3)
      u_cpu.rd(8'h20, q);
      `CHK(q, 32'h00000000)
      u_cpu.wr(HSCCS_OFF_CFG, 32'h00000102);
      u_cpu.wr(HSCCS_OFF_HOME, 32'h0000ABCD);
      tick(1);
      `CHK(home_count, 32'h0000ABCD)
      // A halfword access is not a register access and must leave the count alone.
      u_cpu.xfer(1'b1, 3'h1, HSCCS_OFF_HOME, 32'h00001111, q);
      tick(1);
      `CHK(home_count, 32'h0000ABCD)
      u_cpu.scan(16'h0100);
      home_switch <= 1'b1;
      tick(2);
      marker_in <= 1'b1;
      tick(1);
      marker_in <= 1'b0;
      tick(2);
      `CHK({home_found, status_word[9:8], nload}, {3'b111, 32'd1})
      u_cpu.scan(16'h0000);
      expect_err(HSCCS_ERR_NONE);
      home_switch <= 1'b0;
      u_cpu.scan(16'h0100);
      tick(1);
      `CHK(home_found, 1'b0)
      u_cpu.scan(16'h0000);
      expect_err(HSCCS_ERR_HOME);
      // With the clock enable low nothing may move, not even the watchdog kick.
      ce <= 1'b0;
      strobe_evt <= 4'h1;
      w = wdog_kick;
      tick(2);
      `CHK({wdog_kick, status_word[3:0]}, {w, 4'h0})
      ce <= 1'b1;
      strobe_evt <= 4'h0;
      w = wdog_kick;
      tick(1);
      `CHK(wdog_kick, ~w)
      mem_fault <= 1'b1;
      tick(1);
      mem_fault <= 1'b0;
      tick(3);
      w = wdog_kick;
      tick(4);
      `CHK({module_ready, wdog_kick, error_flag}, {1'b0, w, 1'b0})
      u_cpu.rd(HSCCS_OFF_CODE, q);
      `CHK(q[7:0], HSCCS_ERR_NONE)
      complete_run();
   end
endmodule : counter_command_status_interface_bench
